// File: core/vpic_defs.svh
// register offsets, field positions, reset values and counts of the interrupt controller
`ifndef VPIC_DEFS_SVH
`define VPIC_DEFS_SVH

`define VPIC_OFF_MODE_BASE   12'h000
`define VPIC_OFF_VECT_BASE   12'h080
`define VPIC_OFF_NORM_VEC    12'h100
`define VPIC_OFF_FAST_VEC    12'h104
`define VPIC_OFF_CUR_NUM     12'h108
`define VPIC_OFF_PENDING     12'h10C
`define VPIC_OFF_MASK        12'h110
`define VPIC_OFF_CORE_STAT   12'h114
`define VPIC_OFF_ENABLE      12'h120
`define VPIC_OFF_DISABLE     12'h124
`define VPIC_OFF_CLEAR       12'h128
`define VPIC_OFF_SET         12'h12C
`define VPIC_OFF_END_SERV    12'h130
`define VPIC_OFF_SPUR_VEC    12'h134
`define VPIC_OFF_DEBUG       12'h138
`define VPIC_OFF_FF_EN       12'h140
`define VPIC_OFF_FF_DIS      12'h144
`define VPIC_OFF_FF_STAT     12'h148

`define VPIC_PRIO_LSB        0
`define VPIC_PRIO_MSB        2
`define VPIC_EDGE_BIT        5
`define VPIC_POL_BIT         6
`define VPIC_MODE_W          7

`define VPIC_DBG_PROTECT     0
`define VPIC_DBG_GMASK       1
`define VPIC_CSTAT_FAST      0
`define VPIC_CSTAT_NORM      1

`define VPIC_MODE_RST        7'h00
`define VPIC_WORD_RST        32'h0000_0000
`define VPIC_STACK_DEPTH     8
`define VPIC_NUM_SRC         32

`define VPIC_RESP_OKAY       2'h0
`define VPIC_RESP_SLVERR     2'h2

`endif

// File: core/vpic_pkg.sv
// types shared by the interrupt controller modules
package vpic_pkg;
    typedef logic [4:0]  vpic_idx_t;
    typedef logic [2:0]  vpic_prio_t;
    typedef logic [31:0] vpic_word_t;
    typedef struct packed {
        vpic_prio_t prio;
        vpic_idx_t  idx;
    } vpic_frame_s;
    typedef enum logic [1:0] {
        VPIC_RD_IDLE  = 2'b00,
        VPIC_RD_FETCH = 2'b01,
        VPIC_RD_RESP  = 2'b11
    } vpic_rd_e;
endpackage

// File: core/vpic_vec_if.sv
// port group between the controller and its vector store
`timescale 1ns/10ps
interface vpic_vec_if;
    logic                 wr_en;
    vpic_pkg::vpic_idx_t  wr_idx;
    vpic_pkg::vpic_word_t wr_data;
    logic [3:0]           wr_strb;
    vpic_pkg::vpic_idx_t  rd_idx;
    vpic_pkg::vpic_word_t rd_data;
    modport ctrl (output wr_en, wr_idx, wr_data, wr_strb, rd_idx, input rd_data);
    modport mem  (input wr_en, wr_idx, wr_data, wr_strb, rd_idx, output rd_data);
endinterface

// File: core/vpic_vec_mem.sv
// per-source vector store with registered read data
`timescale 1ns/10ps
`include "vpic_defs.svh"
module vpic_vec_mem
    import vpic_pkg::*;
#(
    parameter int DEPTH = `VPIC_NUM_SRC
) (
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    vpic_vec_if.mem   vec
);
    vpic_word_t mem_ff [DEPTH];
    vpic_word_t rd_ff;

    if (DEPTH != 32) begin : g_chk
        $error("vector store needs 32 entries");
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem_ff[k] <= `VPIC_WORD_RST;
            end
        end else if (vec.wr_en) begin
            for (int b = 0; b < 4; b++) begin
                if (vec.wr_strb[b]) begin
                    mem_ff[vec.wr_idx][8*b +: 8] <= vec.wr_data[8*b +: 8];
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rd_ff <= `VPIC_WORD_RST;
        end else begin
            rd_ff <= mem_ff[vec.rd_idx];
        end
    end

    assign vec.rd_data = rd_ff;
endmodule // vpic_vec_mem

// File: core/vpic_top.sv
// vectored priority interrupt controller with an AXI4-Lite register slave
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "vpic_defs.svh"
module vpic_top
    import vpic_pkg::*;
#(
    parameter int          SYS_LINES    = 4,
    parameter logic [31:0] EXT_SOURCES  = 32'h0000_0001,
    parameter bit          HAS_FAST_PIN = 1'b1
) (
    input  wire logic                 I_CLOCK,
    input  wire logic                 I_RST_B,
    input  wire logic [11:0]          I_AWADDR,
    input  wire logic                 I_AWVALID,
    output wire logic                 O_AWREADY,
    input  wire logic [31:0]          I_WDATA,
    input  wire logic [3:0]           I_WSTRB,
    input  wire logic                 I_WVALID,
    output wire logic                 O_WREADY,
    output logic      [1:0]           O_BRESP,
    output wire logic                 O_BVALID,
    input  wire logic                 I_BREADY,
    input  wire logic [11:0]          I_ARADDR,
    input  wire logic                 I_ARVALID,
    output wire logic                 O_ARREADY,
    output logic      [31:0]          O_RDATA,
    output logic      [1:0]           O_RRESP,
    output wire logic                 O_RVALID,
    input  wire logic                 I_RREADY,
    input  wire logic                 I_FAST_INT_PIN,
    input  wire logic [SYS_LINES-1:0] I_SYSTEM_LINES,
    input  wire logic [31:2]          I_PERIPH_SOURCES,
    output logic                      O_NORMAL_REQUEST_N,
    output logic                      O_FAST_REQUEST_N,
    output logic                      O_WAKEUP
);
    localparam int NS = `VPIC_NUM_SRC;
    localparam int SD = `VPIC_STACK_DEPTH;

    if (SYS_LINES < 1) begin : g_chk
        $error("at least one system line is needed");
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    logic [`VPIC_MODE_W-1:0] mode_ff [NS];
    logic [31:0]             mask_ff;
    logic [31:0]             force_ff;
    vpic_word_t              spur_ff;
    logic                    protect_ff;
    logic                    gmask_ff;
    vpic_idx_t               cur_num_ff;
    vpic_frame_s             stack_ff [SD];
    logic [3:0]              depth_ff;
    logic                    bvalid_ff;
    vpic_rd_e                rd_st_ff;
    vpic_word_t              rd_hold_ff;
    logic                    rd_mem_ff;
    logic [1:0]              rd_resp_ff;

    logic [31:0] raw_src;
    wire  [31:0] pending_w;
    logic [31:0] set_cmd;
    logic [31:0] clr_cmd;
    logic [31:0] auto_clr;
    logic [31:0] norm_cand;
    logic        fast_act;
    logic        best_valid;
    vpic_prio_t  best_prio;
    vpic_idx_t   best_idx;
    vpic_frame_s top_frame;
    logic        norm_act;
    logic        wr_go;
    logic        ar_take;
    logic [31:0] wmask;
    vpic_word_t  wdat;
    logic        push;
    logic        pop;

    vpic_vec_if vec ();

    ////////////////////////////////////////////////////////////////////////////////////////
    // source wiring
    assign raw_src[0]    = HAS_FAST_PIN ? I_FAST_INT_PIN : 1'b0;
    assign raw_src[1]    = |I_SYSTEM_LINES;
    assign raw_src[31:2] = I_PERIPH_SOURCES;

    for (genvar i = 0; i < NS; i++) begin : g_src
        logic sync1_ff;
        logic sync2_ff;
        logic prev_ff;
        logic latch_ff;
        logic s;
        logic pol;
        logic lvl;
        logic edge_hit;
        logic is_edge;

        if (EXT_SOURCES[i]) begin : g_ext
            always_ff @(posedge I_CLOCK) begin
                if (!I_RST_B) begin
                    sync1_ff <= 1'b0;
                    sync2_ff <= 1'b0;
                end else begin
                    sync1_ff <= raw_src[i];
                    sync2_ff <= sync1_ff;
                end
            end
            assign s   = sync2_ff;
            assign pol = mode_ff[i][`VPIC_POL_BIT];
        end else begin : g_int
            assign sync1_ff = 1'b0;
            assign sync2_ff = 1'b0;
            // internal lines are active high by construction
            assign s   = raw_src[i];
            assign pol = 1'b1;
        end

        assign is_edge  = mode_ff[i][`VPIC_EDGE_BIT];
        assign lvl      = pol ? s : ~s;
        assign edge_hit = pol ? (s & ~prev_ff) : (~s & prev_ff);

        always_ff @(posedge I_CLOCK) begin
            if (!I_RST_B) begin
                prev_ff <= 1'b0;
            end else begin
                prev_ff <= s;
            end
        end

        // new events beat a clear in the same cycle
        always_ff @(posedge I_CLOCK) begin
            if (!I_RST_B) begin
                latch_ff <= 1'b0;
            end else if (!is_edge) begin
                latch_ff <= 1'b0;
            end else if (edge_hit || set_cmd[i]) begin
                latch_ff <= 1'b1;
            end else if (clr_cmd[i] || auto_clr[i]) begin
                latch_ff <= 1'b0;
            end
        end

        assign pending_w[i] = is_edge ? latch_ff : lvl;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // arbitration
    assign fast_act  = |(pending_w & mask_ff & (force_ff | 32'h0000_0001));
    assign norm_cand = pending_w & mask_ff & ~force_ff & 32'hFFFF_FFFE;

    always_comb begin
        best_valid = 1'b0;
        best_prio  = 3'h0;
        best_idx   = 5'h00;
        // downward scan with >= leaves the lowest number among equals
        for (int k = NS - 1; k >= 1; k--) begin
            if (norm_cand[k] && (!best_valid ||
                mode_ff[k][`VPIC_PRIO_MSB:`VPIC_PRIO_LSB] >= best_prio)) begin
                best_valid = 1'b1;
                best_prio  = mode_ff[k][`VPIC_PRIO_MSB:`VPIC_PRIO_LSB];
                best_idx   = vpic_idx_t'(k);
            end
        end
    end

    assign top_frame = (depth_ff != 4'h0) ? stack_ff[depth_ff[2:0] - 3'h1] : '0;
    assign norm_act  = best_valid &&
                       ((depth_ff == 4'h0) || (best_prio > top_frame.prio));

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            O_NORMAL_REQUEST_N <= 1'b1;
            O_FAST_REQUEST_N   <= 1'b1;
            O_WAKEUP           <= 1'b0;
        end else begin
            O_NORMAL_REQUEST_N <= ~(norm_act & ~gmask_ff);
            O_FAST_REQUEST_N   <= ~(fast_act & ~gmask_ff);
            O_WAKEUP           <= norm_act | fast_act;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // write channel: address and data are taken together
    assign wr_go     = I_AWVALID && I_WVALID && !bvalid_ff;
    assign O_AWREADY = wr_go;
    assign O_WREADY  = wr_go;
    assign O_BVALID  = bvalid_ff;

    for (genvar b = 0; b < 4; b++) begin : g_strb
        assign wmask[8*b +: 8] = {8{I_WSTRB[b]}};
    end
    assign wdat = I_WDATA & wmask;

    assign set_cmd = (wr_go && I_AWADDR == `VPIC_OFF_SET)   ? wdat : 32'h0000_0000;
    assign clr_cmd = (wr_go && I_AWADDR == `VPIC_OFF_CLEAR) ? wdat : 32'h0000_0000;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            bvalid_ff <= 1'b0;
            O_BRESP   <= `VPIC_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            O_BRESP   <= (I_AWADDR[11:8] == 4'h0 ||
                          (I_AWADDR >= `VPIC_OFF_NORM_VEC && I_AWADDR <= `VPIC_OFF_FF_STAT))
                         ? `VPIC_RESP_OKAY : `VPIC_RESP_SLVERR;
        end else if (I_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            for (int k = 0; k < NS; k++) begin
                mode_ff[k] <= `VPIC_MODE_RST;
            end
        end else if (wr_go && I_AWADDR[11:7] == 5'h00 && I_WSTRB[0]) begin
            mode_ff[I_AWADDR[6:2]] <= I_WDATA[`VPIC_MODE_W-1:0];
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            mask_ff <= `VPIC_WORD_RST;
        end else if (wr_go && I_AWADDR == `VPIC_OFF_ENABLE) begin
            mask_ff <= mask_ff | wdat;
        end else if (wr_go && I_AWADDR == `VPIC_OFF_DISABLE) begin
            mask_ff <= mask_ff & ~wdat;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            force_ff <= `VPIC_WORD_RST;
        end else if (wr_go && I_AWADDR == `VPIC_OFF_FF_EN) begin
            force_ff <= force_ff | wdat;
        end else if (wr_go && I_AWADDR == `VPIC_OFF_FF_DIS) begin
            force_ff <= force_ff & ~wdat;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            spur_ff    <= `VPIC_WORD_RST;
            protect_ff <= 1'b0;
            gmask_ff   <= 1'b0;
        end else if (wr_go && I_AWADDR == `VPIC_OFF_SPUR_VEC) begin
            spur_ff <= (spur_ff & ~wmask) | wdat;
        end else if (wr_go && I_AWADDR == `VPIC_OFF_DEBUG && I_WSTRB[0]) begin
            protect_ff <= I_WDATA[`VPIC_DBG_PROTECT];
            gmask_ff   <= I_WDATA[`VPIC_DBG_GMASK];
        end
    end

    assign vec.wr_en   = wr_go && I_AWADDR[11:7] == 5'h01;
    assign vec.wr_idx  = I_AWADDR[6:2];
    assign vec.wr_data = I_WDATA;
    assign vec.wr_strb = I_WSTRB;

    ////////////////////////////////////////////////////////////////////////////////////////
    // read channel and vector-read side effects
    assign ar_take   = I_ARVALID && rd_st_ff == VPIC_RD_IDLE;
    assign O_ARREADY = rd_st_ff == VPIC_RD_IDLE;
    assign O_RVALID  = rd_st_ff == VPIC_RD_RESP;

    // side effects act on the arbitration result at the edge the address is taken
    assign push = ar_take && I_ARADDR == `VPIC_OFF_NORM_VEC && !protect_ff && best_valid;
    assign pop  = wr_go && I_AWADDR == `VPIC_OFF_END_SERV && depth_ff != 4'h0;

    always_comb begin
        auto_clr = 32'h0000_0000;
        if (push) begin
            auto_clr[best_idx] = 1'b1;
        end
        if (ar_take && I_ARADDR == `VPIC_OFF_FAST_VEC && !protect_ff) begin
            auto_clr[0] = 1'b1;
        end
    end

    // stack cannot overflow: a push is not stored once depth_ff reaches SD (8)
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            depth_ff <= 4'h0;
            for (int k = 0; k < SD; k++) begin
                stack_ff[k] <= '0;
            end
        end else if (push && depth_ff != 4'(SD)) begin
            stack_ff[depth_ff[2:0]] <= '{prio: best_prio, idx: best_idx};
            depth_ff                <= depth_ff + 4'h1;
        end else if (pop) begin
            depth_ff <= depth_ff - 4'h1;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            cur_num_ff <= 5'h00;
        end else if (push) begin
            cur_num_ff <= best_idx;
        end else if (pop && depth_ff > 4'h1) begin
            cur_num_ff <= stack_ff[depth_ff[2:0] - 3'h2].idx;
        end
    end

    always_comb begin
        vec.rd_idx = I_ARADDR[6:2];
        if (I_ARADDR == `VPIC_OFF_NORM_VEC) begin
            vec.rd_idx = best_idx;
        end else if (I_ARADDR == `VPIC_OFF_FAST_VEC) begin
            vec.rd_idx = 5'h00;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            rd_st_ff <= VPIC_RD_IDLE;
        end else begin
            case (rd_st_ff)
                VPIC_RD_IDLE: begin
                    if (I_ARVALID) begin
                        rd_st_ff <= VPIC_RD_FETCH;
                    end
                end
                VPIC_RD_FETCH: begin
                    rd_st_ff <= VPIC_RD_RESP;
                end
                VPIC_RD_RESP: begin
                    if (I_RREADY) begin
                        rd_st_ff <= VPIC_RD_IDLE;
                    end
                end
                default: begin
                    rd_st_ff <= VPIC_RD_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            rd_hold_ff <= `VPIC_WORD_RST;
            rd_mem_ff  <= 1'b0;
            rd_resp_ff <= `VPIC_RESP_OKAY;
        end else if (ar_take) begin
            rd_mem_ff  <= 1'b0;
            rd_hold_ff <= `VPIC_WORD_RST;
            rd_resp_ff <= `VPIC_RESP_OKAY;
            if (I_ARADDR[11:7] == 5'h00) begin
                rd_hold_ff <= {25'h000_0000, mode_ff[I_ARADDR[6:2]]};
            end else if (I_ARADDR[11:7] == 5'h01 || I_ARADDR == `VPIC_OFF_FAST_VEC) begin
                rd_mem_ff <= 1'b1;
            end else begin
                case (I_ARADDR)
                    `VPIC_OFF_NORM_VEC: begin
                        rd_mem_ff  <= best_valid;
                        rd_hold_ff <= spur_ff;
                    end
                    `VPIC_OFF_CUR_NUM:   rd_hold_ff <= {27'h000_0000, cur_num_ff};
                    `VPIC_OFF_PENDING:   rd_hold_ff <= pending_w;
                    `VPIC_OFF_MASK:      rd_hold_ff <= mask_ff;
                    `VPIC_OFF_CORE_STAT: begin
                        rd_hold_ff[`VPIC_CSTAT_FAST] <= ~O_FAST_REQUEST_N;
                        rd_hold_ff[`VPIC_CSTAT_NORM] <= ~O_NORMAL_REQUEST_N;
                    end
                    `VPIC_OFF_SPUR_VEC:  rd_hold_ff <= spur_ff;
                    `VPIC_OFF_DEBUG: begin
                        rd_hold_ff[`VPIC_DBG_PROTECT] <= protect_ff;
                        rd_hold_ff[`VPIC_DBG_GMASK]   <= gmask_ff;
                    end
                    `VPIC_OFF_FF_STAT:   rd_hold_ff <= force_ff;
                    `VPIC_OFF_ENABLE, `VPIC_OFF_DISABLE, `VPIC_OFF_CLEAR, `VPIC_OFF_SET,
                    `VPIC_OFF_END_SERV, `VPIC_OFF_FF_EN, `VPIC_OFF_FF_DIS: begin
                        rd_hold_ff <= `VPIC_WORD_RST;
                    end
                    default:             rd_resp_ff <= `VPIC_RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            O_RDATA <= `VPIC_WORD_RST;
            O_RRESP <= `VPIC_RESP_OKAY;
        end else if (rd_st_ff == VPIC_RD_FETCH) begin
            O_RDATA <= rd_mem_ff ? vec.rd_data : rd_hold_ff;
            O_RRESP <= rd_resp_ff;
        end
    end

    vpic_vec_mem #(
        .DEPTH (NS)
    ) u_vec_mem (
        .i_clk   (I_CLOCK),
        .i_rst_b (I_RST_B),
        .vec     (vec)
    );
endmodule // vpic_top

// File: tb/vpic_top_sva.sv
// port-level checks of the interrupt controller
`timescale 1ns/10ps
module vpic_top_sva (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RST_B,
    input  wire logic [11:0] I_AWADDR,
    input  wire logic        I_AWVALID,
    input  wire logic        O_AWREADY,
    input  wire logic        I_WVALID,
    input  wire logic        O_WREADY,
    input  wire logic [1:0]  O_BRESP,
    input  wire logic        O_BVALID,
    input  wire logic        I_BREADY,
    input  wire logic        I_ARVALID,
    input  wire logic        O_ARREADY,
    input  wire logic [31:0] O_RDATA,
    input  wire logic        O_RVALID,
    input  wire logic        I_RREADY,
    input  wire logic        O_NORMAL_REQUEST_N,
    input  wire logic        O_FAST_REQUEST_N,
    input  wire logic        O_WAKEUP
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_B);
    ////////////////////////////////////////////////////////////////////////////////
    property p_wr_ans; I_AWVALID && I_WVALID && O_AWREADY |=> O_BVALID; endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_unmap; I_AWVALID && I_WVALID && O_AWREADY && I_AWADDR == 12'h200 |=> O_BRESP == 2'h2; endproperty
    a_unmap: assert property (p_unmap) else $error("no error response");
    property p_b_hold; O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_busy; O_BVALID |-> !O_AWREADY && !O_WREADY; endproperty
    a_busy: assert property (p_busy) else $error("write taken while busy");
    property p_rd_ans; I_ARVALID && O_ARREADY |=> !O_ARREADY ##1 O_RVALID; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read latency wrong");
    property p_r_hold; O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA); endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_r_done; O_RVALID && I_RREADY |=> !O_RVALID && O_ARREADY; endproperty
    a_r_done: assert property (p_r_done) else $error("read not closed");
    // wake is registered on the same edge as the requests; the check allows one cycle of slack
    property p_wake; !O_NORMAL_REQUEST_N || !O_FAST_REQUEST_N |-> ##[0:1] O_WAKEUP; endproperty
    a_wake: assert property (p_wake) else $error("request without wake");
endmodule // vpic_top_sva
bind vpic_top vpic_top_sva i_vpic_top_sva (.*);

// File: tb/vpic_src_model.sv
// source-side model: drives the interrupt lines from a bench command
`timescale 1ns/10ps
module vpic_src_model (
    input  wire logic        i_clk,
    input  wire logic [3:0]  i_cmd,
    output logic             o_fast_pin = 1'b1,
    output logic [3:0]       o_sys = 4'h0,
    output logic [31:2]      o_periph = 30'h0000_0000
);
    // lines change after the edge like a peripheral flop would
    always @(posedge i_clk) begin
        o_fast_pin <= i_cmd[0];
        o_sys      <= {3'h0, i_cmd[1]};
        o_periph   <= {28'h000_0000, i_cmd[3:2]};
    end
endmodule // vpic_src_model

// File: tb/vpic_top_tb.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
module vpic_top_tb;
    typedef struct {
        logic [2:0]  pins;
        logic [3:0]  src;
        logic        wr;
        logic [11:0] a;
        logic [15:0] d;
        logic [15:0] x;
    } vpic_row_s;
    // pins {wake, fast_n, normal_n} before access; src {src3, src2, sys0, fast pin}
    vpic_row_s rows [28] = '{
        '{3'h3,4'h1,1'h1,12'h134,16'hA5A5,16'h0000},
        '{3'h3,4'h1,1'h0,12'h134,16'h0000,16'hA5A5},
        '{3'h3,4'h1,1'h1,12'h008,16'h0023,16'h0000},
        '{3'h3,4'h1,1'h1,12'h00C,16'h0005,16'h0000},
        '{3'h3,4'h1,1'h1,12'h088,16'h2222,16'h0000},
        '{3'h3,4'h1,1'h1,12'h08C,16'h3333,16'h0000},
        '{3'h3,4'h1,1'h1,12'h120,16'h000C,16'h0000},
        '{3'h3,4'h1,1'h0,12'h110,16'h0000,16'h000C},
        '{3'h3,4'h1,1'h0,12'h100,16'h0000,16'hA5A5},
        '{3'h6,4'h5,1'h0,12'h10C,16'h0000,16'h0004},
        '{3'h6,4'h9,1'h0,12'h100,16'h0000,16'h3333},
        '{3'h3,4'h9,1'h0,12'h108,16'h0000,16'h0003},
        '{3'h3,4'h1,1'h1,12'h130,16'h0000,16'h0000},
        '{3'h6,4'h1,1'h0,12'h100,16'h0000,16'h2222},
        '{3'h3,4'h1,1'h0,12'h10C,16'h0000,16'h0000},
        '{3'h3,4'h1,1'h1,12'h130,16'h0000,16'h0000},
        '{3'h3,4'h1,1'h1,12'h12C,16'h0004,16'h0000},
        '{3'h6,4'h1,1'h1,12'h128,16'h0004,16'h0000},
        '{3'h3,4'h1,1'h1,12'h12C,16'h0008,16'h0000},
        '{3'h3,4'h1,1'h0,12'h10C,16'h0000,16'h0000},
        '{3'h3,4'h1,1'h1,12'h124,16'h0004,16'h0000},
        '{3'h3,4'h1,1'h1,12'h12C,16'h0004,16'h0000},
        '{3'h3,4'h1,1'h0,12'h10C,16'h0000,16'h0004},
        '{3'h3,4'h1,1'h1,12'h140,16'h0008,16'h0000},
        '{3'h5,4'h9,1'h0,12'h148,16'h0000,16'h0008},
        '{3'h5,4'h9,1'h1,12'h138,16'h0002,16'h0000},
        '{3'h7,4'h9,1'h0,12'h114,16'h0000,16'h0000},
        '{3'h3,4'h1,1'h1,12'h200,16'h0000,16'h0002}
    };
    logic             clk = 1'b0, rst_b = 1'b0, awv = 1'b0, wv = 1'b0;
    logic             bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [11:0]      awaddr = 12'h000, araddr = 12'h000;
    logic [31:0]      wdata = 32'h0000_0000, v;
    logic [3:0]       cmd = 4'h1;
    logic [1:0]       r;
    int               err_total = 0, checks_done = 0;
    wire logic        awrdy, wrdy, bv, arrdy, rv, fpin, norm_n, fast_n, wake;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [3:0]  system_source;
    wire logic [31:2] per;
    wire logic [3:0]  hs = {rv, arrdy, bv, awrdy};

    vpic_top i_vpic_top (.I_CLOCK(clk), .I_RST_B(rst_b), .I_AWADDR(awaddr), .I_AWVALID(awv),
        .O_AWREADY(awrdy), .I_WDATA(wdata), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wrdy),
        .O_BRESP(bresp), .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
        .O_ARREADY(arrdy), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv), .I_RREADY(rready),
        .I_FAST_INT_PIN(fpin), .I_SYSTEM_LINES(system_source), .I_PERIPH_SOURCES(per),
        .O_NORMAL_REQUEST_N(norm_n), .O_FAST_REQUEST_N(fast_n), .O_WAKEUP(wake));
    vpic_src_model i_vpic_src_model (.i_clk(clk), .i_cmd(cmd), .o_fast_pin(fpin), .o_sys(system_source),
        .o_periph(per));

    initial begin
        forever #25 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // bounded wait for one handshake flag at a rising edge
    task automatic await(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n > 50) begin
                err_total++;
                $display("MISMATCH t=%0t handshake %0d timed out", $time, k);
                test_done();
            end
        end while (hs[k] !== 1'b1);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'b1;
        wv     <= 1'b1;
        await(0);
        awv    <= 1'b0;
        wv     <= 1'b0;
        bready <= 1'b1;
        await(1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        araddr <= a;
        arv    <= 1'b1;
        await(2);
        arv    <= 1'b0;
        rready <= 1'b1;
        await(3);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 28; i++) begin
            cmd <= rows[i].src;
            repeat (8) @(posedge clk);
            chk({29'h0000_0000, wake, fast_n, norm_n}, {29'h0000_0000, rows[i].pins});
            if (rows[i].wr) begin
                wr(rows[i].a, {16'h0000, rows[i].d}, r);
                v = {30'h0000_0000, r};
            end else begin
                rd(rows[i].a, v);
                chk({30'h0000_0000, r}, 32'h0000_0000);
            end
            chk(v, {16'h0000, rows[i].x});
        end
        // reset with no vector taken must drop the live fast request
        cmd <= 4'h9;
        wr(12'h138, 32'h0000_0000, r);
        repeat (8) @(posedge clk);
        chk({29'h0000_0000, wake, fast_n, norm_n}, 32'h0000_0005);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        chk({29'h0000_0000, wake, fast_n, norm_n}, 32'h0000_0003);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        chk({29'h0000_0000, wake, fast_n, norm_n}, 32'h0000_0003);
        rd(12'h148, v);
        chk(v, 32'h0000_0000);
        rd(12'h200, v);
        chk(v, 32'h0000_0000);
        chk({30'h0000_0000, r}, 32'h0000_0002);
        // protected fast vector read keeps the latch, an open one clears it
        wr(12'h000, 32'h0000_0020, r);
        wr(12'h120, 32'h0000_0001, r);
        wr(12'h138, 32'h0000_0001, r);
        wr(12'h12C, 32'h0000_0001, r);
        rd(12'h104, v);
        repeat (8) @(posedge clk);
        chk({29'h0000_0000, wake, fast_n, norm_n}, 32'h0000_0005);
        wr(12'h138, 32'h0000_0000, r);
        rd(12'h104, v);
        repeat (8) @(posedge clk);
        chk({29'h0000_0000, wake, fast_n, norm_n}, 32'h0000_0003);
        test_done();
    end
endmodule // vpic_top_tb
